// ===== verilog/sacq_pkg.sv
// Shared constants and types for the scanned acquisition sequencer.
// Assumes a single 10 MHz system clock and a plain register port.
package sacq_pkg;

  // Register index map on the 4-bit register address.
  localparam logic [3:0] REG_CMD1    = 4'h0;  // Command register one.
  localparam logic [3:0] REG_STATUS  = 4'h1;  // Status, read only.
  localparam logic [3:0] REG_FIFO    = 4'h2;  // Result FIFO head, read pops.
  localparam logic [3:0] REG_ADCLR   = 4'h3;  // Converter clear, write only.
  localparam logic [3:0] REG_MUXCNT  = 4'h4;  // Mux counter.
  localparam logic [3:0] REG_MUXGAIN = 4'h5;  // Scan memory entry at mux counter.
  localparam logic [3:0] REG_START   = 4'h6;  // Software start trigger.
  localparam logic [3:0] REG_CTRDATA = 4'h8;  // Counter chip data port.
  localparam logic [3:0] REG_CTRCMD  = 4'h9;  // Counter chip command port.

  // Command register one bit positions.
  localparam int CMD1_ACQ_EN  = 0;
  localparam int CMD1_SCAN_EN = 1;
  localparam int CMD1_WIDTH   = 2;
  localparam int CMD1_SCAN_DIVIDE = 3;
  localparam logic [3:0] CMD1_RST = 4'h0;

  // Status register bit positions.
  localparam int ST_AVAIL = 0;
  localparam int ST_OVFL  = 1;
  localparam int ST_OVRN  = 2;
  localparam int ST_RUN   = 3;

  // Scan memory entry field positions in the write data.
  localparam int ENT_CHAN_LSB = 0;
  localparam int ENT_GAIN_LSB = 6;
  localparam int ENT_LAST     = 8;

  // Counter chip commands.
  localparam logic [15:0] CC_SEL_M3  = 16'hFF03;
  localparam logic [15:0] CC_SEL_L3  = 16'hFF0B;
  localparam logic [15:0] CC_SEL_M4  = 16'hFF04;
  localparam logic [15:0] CC_SEL_L4  = 16'hFF0C;
  localparam logic [15:0] CC_SEL_M5  = 16'hFF05;
  localparam logic [15:0] CC_SEL_L5  = 16'hFF0D;
  localparam logic [15:0] CC_LOAD3   = 16'hFF44;
  localparam logic [15:0] CC_STEP3   = 16'hFFF3;
  localparam logic [15:0] CC_ARM3    = 16'hFF24;
  localparam logic [15:0] CC_LOAD4   = 16'hFF48;
  localparam logic [15:0] CC_STEP4   = 16'hFFF4;
  localparam logic [15:0] CC_ARM4    = 16'hFF28;
  localparam logic [15:0] CC_LDARM5  = 16'hFF70;

  // Interval counter mode values, one per timebase.
  localparam logic [15:0] MODE_1MHZ   = 16'h8B25;
  localparam logic [15:0] MODE_100KHZ = 16'h8C25;
  localparam logic [15:0] MODE_10KHZ  = 16'h8D25;
  localparam logic [15:0] MODE_1KHZ   = 16'h8E25;
  localparam logic [15:0] MODE_100HZ  = 16'h8F25;
  localparam logic [15:0] MODE_EXT    = 16'h8525;
  localparam logic [15:0] WORD_RST    = 16'h0000;

  // Timebase derivation from the system clock.
  localparam int SYS_CLK_HZ  = 10_000_000;
  localparam int TB_FAST_HZ  = 1_000_000;
  localparam int TB_FAST_DIV = SYS_CLK_HZ / TB_FAST_HZ;
  localparam int DECADE      = 10;
  localparam int TB_STAGES   = 5;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;

  // Counter chip register pointer.
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000, SEL_M3 = 3'b001, SEL_L3 = 3'b010, SEL_M4 = 3'b011,
    SEL_L4 = 3'b100, SEL_M5 = 3'b101, SEL_L5 = 3'b110
  } sacq_sel_e;

  // Acquisition run state.
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00, RUN_ACTIVE = 2'b01, RUN_DRAIN = 2'b10
  } sacq_run_e;

  // One channel/gain scan memory entry.
  typedef struct packed {
    logic       last;
    logic [1:0] gain;
    logic [3:0] chan;
  } sacq_entry_s;

endpackage

// ===== verilog/sacq_fifo.sv
// Result FIFO for the scanned acquisition sequencer.
// Assumes push, pop and clear come from logic on the same clock.
`timescale 1ns/1ns
module sacq_fifo
  import sacq_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic        i_clear,    // Empties the FIFO.
  input  wire logic        i_push,
  input  wire logic [15:0] i_data,
  input  wire logic        i_pop,
  output logic [15:0]      o_data,     // Head word.
  output logic             o_empty,
  output logic             o_full
);

  logic [15:0]        mem_q [FIFO_DEPTH];  // Storage.
  logic [FIFO_AW:0]   wp_q;                // Write pointer with wrap bit.
  logic [FIFO_AW:0]   rp_q;                // Read pointer with wrap bit.
  logic               do_push;
  logic               do_pop;

  // A full FIFO drops the push; the owner counts that as overflow.
  assign do_push = i_push && !o_full;
  assign do_pop  = i_pop && !o_empty;
  assign o_empty = (wp_q == rp_q);
  assign o_full  = (wp_q[FIFO_AW] != rp_q[FIFO_AW]) &&
                   (wp_q[FIFO_AW-1:0] == rp_q[FIFO_AW-1:0]);
  assign o_data  = mem_q[rp_q[FIFO_AW-1:0]];

  // Storage write; words leave in the order they came in.
  always_ff @(posedge i_sys_clk) begin
    if (do_push) begin
      mem_q[wp_q[FIFO_AW-1:0]] <= i_data;
    end
  end

  // Pointers; clear wins over everything so no stale result survives.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || i_clear) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

endmodule // sacq_fifo

// ===== verilog/sacq_top.sv
// Scanned acquisition sequencer: interval and sample counters, scan memory,
// trigger, converter handshake, result FIFO and status flags.
// Assumes converter handshake on the system clock; trigger, external
// timebase and counter-one output come from pins and are synchronised.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
// Function
// - Interval counter pulses every N timebase counts.
// - Mode value selects timebase or external edges.
// - Chip takes load, decrement, arm commands.
// - Width bit picks one or two stages.
// - Both stages zero and last entry end.
// - Converter clear with zero data empties the result FIFO.
// - Mux counter zero selects first entry.
// - Trigger needs acquisition and scan enable.
// - Start by software write of zero or pin pulse.
// - One conversion per interval until count done.
// - Status shows result waiting flag.
// - Seventeenth unread result: overflow, halt.
// - Conversion while busy: overrun, halt.
// - Converter clear clears both error flags.
// - Mux steps per conversion or counter-one pulse.
module sacq_top
  import sacq_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic [3:0]  i_addr,               // Register index.
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,              // Valid the cycle after i_rd.
  input  wire logic        i_start_trigger_n,    // Pin, active low pulse.
  input  wire logic        i_external_timebase_input,  // Pin, rising edges.
  input  wire logic        i_counter_one_output, // Pin, low pulses step scan.
  output logic             o_conv_start,         // One-cycle conversion pulse.
  output sacq_entry_s      o_mux_sel,            // Selected channel and gain.
  input  wire logic        i_conv_done,          // Converter finished.
  input  wire logic [15:0] i_conv_data
);

  logic [3:0]  cmd1_q;             // Command register one.
  logic [15:0] mode3_q, l3_q, c3_q; // Interval counter mode, load, count.
  logic [15:0] l4_q, c4_q;         // First sample stage load and count.
  logic [15:0] l5_q, c5_q;         // Second sample stage load and count.
  logic        a3_q, a4_q, a5_q;   // Armed flags.
  sacq_sel_e   sel_q;              // Counter chip register pointer.
  sacq_run_e   run_q;              // Run state.
  logic        ovfl_q, ovrn_q;     // Sticky error flags.
  logic        busy_q;             // Conversion in flight.
  logic [3:0]  mux_q;              // Mux counter.
  sacq_entry_s scan_mem_q [16];    // Channel/gain scan memory.
  logic [15:0] rdata_q;
  logic [2:0]  trg_sync_q, ext_sync_q, c1_sync_q;  // Pin synchronisers.
  logic [3:0]  tb_cnt_q [TB_STAGES];  // Decade divider chain.
  logic [TB_STAGES-1:0] tb_tick;
  logic        tb_sel, running, trig, conv_pulse, tc4, ovrn_evt, ovfl_evt;
  logic        wr_cmd, wr_data, wr_clr, rd_fifo, step_mux, stop_now;
  logic        fifo_empty, fifo_full;
  logic [15:0] fifo_data;
  sacq_entry_s cur;

  assign wr_cmd  = i_wr && (i_addr == REG_CTRCMD);
  assign wr_data = i_wr && (i_addr == REG_CTRDATA);
  assign wr_clr  = i_wr && (i_addr == REG_ADCLR);
  assign rd_fifo = i_rd && (i_addr == REG_FIFO);
  assign running = (run_q != RUN_IDLE);
  assign cur     = scan_mem_q[mux_q];

  // Pins pass three flops; only the second and third stages are inspected.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      trg_sync_q <= 3'h7;
      ext_sync_q <= 3'h0;
      c1_sync_q  <= 3'h7;
    end else begin
      trg_sync_q <= {trg_sync_q[1:0], i_start_trigger_n};
      ext_sync_q <= {ext_sync_q[1:0], i_external_timebase_input};
      c1_sync_q  <= {c1_sync_q[1:0], i_counter_one_output};
    end
  end

  // Decade chain: stage 0 is 1 MHz, each next stage a tenth of it.
  for (genvar s = 0; s < TB_STAGES; s++) begin : g_tb
    localparam logic [3:0] TOP = (s == 0) ? 4'(TB_FAST_DIV - 1) : 4'(DECADE - 1);
    logic adv;
    if (s == 0) begin : g_first
      assign adv = 1'b1;
    end else begin : g_next
      assign adv = tb_tick[s-1];
    end
    assign tb_tick[s] = adv && (tb_cnt_q[s] == TOP);
    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        tb_cnt_q[s] <= 4'h0;
      end else if (adv) begin
        tb_cnt_q[s] <= tb_tick[s] ? 4'h0 : tb_cnt_q[s] + 4'h1;
      end
    end
  end

  // Timebase select; an unknown mode leaves the interval counter idle.
  always_comb begin
    case (mode3_q)
      MODE_1MHZ:   tb_sel = tb_tick[0];
      MODE_100KHZ: tb_sel = tb_tick[1];
      MODE_10KHZ:  tb_sel = tb_tick[2];
      MODE_1KHZ:   tb_sel = tb_tick[3];
      MODE_100HZ:  tb_sel = tb_tick[4];
      MODE_EXT:    tb_sel = ext_sync_q[1] && !ext_sync_q[2];
      default:     tb_sel = 1'b0;
    endcase
  end

  // Interval counter fires when it sits at one on a timebase count.
  assign conv_pulse = running && a3_q && tb_sel && (c3_q == 16'h0001);
  assign ovrn_evt   = conv_pulse && busy_q && !i_conv_done;
  assign ovfl_evt   = i_conv_done && fifo_full;
  assign tc4        = a4_q && (c4_q == 16'h0000);
  assign trig       = (i_wr && (i_addr == REG_START) && (i_wdata == WORD_RST)) ||
                      (!trg_sync_q[1] && trg_sync_q[2]);

  // Counter chip register pointer follows the select commands.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sel_q <= SEL_NONE;
    end else if (wr_cmd) begin
      case (i_wdata)
        CC_SEL_M3: sel_q <= SEL_M3;
        CC_SEL_L3: sel_q <= SEL_L3;
        CC_SEL_M4: sel_q <= SEL_M4;
        CC_SEL_L4: sel_q <= SEL_L4;
        CC_SEL_M5: sel_q <= SEL_M5;
        CC_SEL_L5: sel_q <= SEL_L5;
        default:   sel_q <= sel_q;
      endcase
    end
  end

  // Interval mode and load words go where the pointer points; stage mode words are dropped.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      mode3_q <= WORD_RST;
      l3_q    <= WORD_RST;
      l4_q    <= WORD_RST;
      l5_q    <= WORD_RST;
    end else if (wr_data) begin
      case (sel_q)
        SEL_M3:  mode3_q <= i_wdata;
        SEL_L3:  l3_q    <= i_wdata;
        SEL_L4:  l4_q    <= i_wdata;
        SEL_L5:  l5_q    <= i_wdata;
        default: l3_q    <= l3_q;
      endcase
    end
  end

  // Interval counter; a load of zero wraps through 65536 counts.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      c3_q <= WORD_RST;
      a3_q <= 1'b0;
    end else if (wr_cmd && (i_wdata == CC_LOAD3)) begin
      c3_q <= l3_q;
    end else if (wr_cmd && (i_wdata == CC_STEP3)) begin
      c3_q <= c3_q - 16'h0001;
    end else if (wr_cmd && (i_wdata == CC_ARM3)) begin
      a3_q <= 1'b1;
    end else if (conv_pulse) begin
      c3_q <= l3_q;
    end else if (running && a3_q && tb_sel) begin
      c3_q <= c3_q - 16'h0001;
    end
  end

  // Sample stages: the first counts conversions and wraps, the second
  // counts first-stage terminal counts in the cascaded mode.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      c4_q <= WORD_RST;
      c5_q <= WORD_RST;
      a4_q <= 1'b0;
      a5_q <= 1'b0;
    end else if (wr_cmd && (i_wdata == CC_LOAD4)) begin
      c4_q <= l4_q;
      a4_q <= 1'b1;
    end else if (wr_cmd && (i_wdata == CC_STEP4)) begin
      c4_q <= c4_q - 16'h0001;
    end else if (wr_cmd && (i_wdata == CC_ARM4)) begin
      a4_q <= 1'b1;
    end else if (wr_cmd && (i_wdata == CC_LDARM5)) begin
      c5_q <= l5_q;
      a5_q <= 1'b1;
    end else if (conv_pulse && a4_q) begin
      c4_q <= c4_q - 16'h0001;
      if (tc4 && cmd1_q[CMD1_WIDTH] && a5_q && (c5_q != WORD_RST)) begin
        c5_q <= c5_q - 16'h0001;
      end
    end
  end

  // Run ends on a single-stage terminal count, on both stages at zero
  // once the last scan entry is served, or on any error.
  always_comb begin
    stop_now = 1'b0;
    if (conv_pulse && tc4) begin
      if (!cmd1_q[CMD1_WIDTH]) begin
        stop_now = 1'b1;
      end else if (c5_q == WORD_RST) begin
        stop_now = cur.last || !cmd1_q[CMD1_SCAN_EN];
      end
    end
  end

  // Run state machine.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      run_q <= RUN_IDLE;
    end else begin
      case (run_q)
        RUN_IDLE: begin
          if (trig && cmd1_q[CMD1_ACQ_EN] && cmd1_q[CMD1_SCAN_EN] &&
              !ovfl_q && !ovrn_q) begin
            run_q <= RUN_ACTIVE;
          end
        end
        RUN_ACTIVE: begin
          if (ovfl_evt || ovrn_evt || stop_now || !cmd1_q[CMD1_ACQ_EN]) begin
            run_q <= RUN_IDLE;
          end else if (conv_pulse && tc4 && cmd1_q[CMD1_WIDTH] &&
                       (c5_q == WORD_RST)) begin
            run_q <= RUN_DRAIN;
          end
        end
        RUN_DRAIN: begin
          if (ovfl_evt || ovrn_evt || !cmd1_q[CMD1_ACQ_EN] ||
              (conv_pulse && cur.last)) begin
            run_q <= RUN_IDLE;
          end
        end
        default: run_q <= RUN_IDLE;
      endcase
    end
  end

  // Converter handshake; an overlapping start is refused, not issued.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      busy_q       <= 1'b0;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= conv_pulse && !ovrn_evt;
      if (conv_pulse && !ovrn_evt) begin
        busy_q <= 1'b1;
      end else if (i_conv_done) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Error flags; a new event in the clearing cycle wins over the clear.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ovfl_q <= 1'b0;
      ovrn_q <= 1'b0;
    end else begin
      ovfl_q <= ovfl_evt || (ovfl_q && !wr_clr);
      ovrn_q <= ovrn_evt || (ovrn_q && !wr_clr);
    end
  end

  // Command register one.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cmd1_q <= CMD1_RST;
    end else if (i_wr && (i_addr == REG_CMD1)) begin
      cmd1_q <= i_wdata[3:0];
    end
  end

  // Mux stepping: per conversion, or per counter-one low pulse.
  assign step_mux = cmd1_q[CMD1_SCAN_EN] &&
                    (cmd1_q[CMD1_SCAN_DIVIDE] ? (!c1_sync_q[1] && c1_sync_q[2])
                                          : o_conv_start);

  // Mux counter; software writes win over a step in the same cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      mux_q <= 4'h0;
    end else if (i_wr && (i_addr == REG_MUXCNT)) begin
      mux_q <= i_wdata[3:0];
    end else if (step_mux) begin
      mux_q <= cur.last ? 4'h0 : mux_q + 4'h1;
    end
  end

  // Scan memory is loaded at the mux counter position; no reset needed.
  always_ff @(posedge i_sys_clk) begin
    if (i_wr && (i_addr == REG_MUXGAIN)) begin
      scan_mem_q[mux_q] <= '{last: i_wdata[ENT_LAST],
                             gain: i_wdata[ENT_GAIN_LSB +: 2],
                             chan: i_wdata[ENT_CHAN_LSB +: 4]};
    end
  end

  // Registered selection to the analog front end.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_mux_sel <= '0;
    end else begin
      o_mux_sel <= cur;
    end
  end

  sacq_fifo u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_clear   (wr_clr && (i_wdata == WORD_RST)),
    .i_push    (i_conv_done),
    .i_data    (i_conv_data),
    .i_pop     (rd_fifo),
    .o_data    (fifo_data),
    .o_empty   (fifo_empty),
    .o_full    (fifo_full)
  );

  // Read data, valid only in the cycle after the read strobe.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_rd) begin
      rdata_q <= WORD_RST;
    end else begin
      case (i_addr)
        REG_CMD1:   rdata_q <= {12'h000, cmd1_q};
        REG_STATUS: rdata_q <= {12'h000, running, ovrn_q, ovfl_q, !fifo_empty};
        REG_FIFO:   rdata_q <= fifo_empty ? WORD_RST : fifo_data;
        REG_MUXCNT: rdata_q <= {12'h000, mux_q};
        default:    rdata_q <= WORD_RST;
      endcase
    end
  end
  assign o_rdata = rdata_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  sequence s_armed_trigger;
    trig && cmd1_q[CMD1_ACQ_EN] && cmd1_q[CMD1_SCAN_EN] && !ovfl_q && !ovrn_q;
  endsequence

  interval_reload_a: assert property (conv_pulse |=> c3_q == $past(l3_q))
    else $error("interval counter did not reload");
  run_start_a: assert property ((run_q == RUN_IDLE) ##0 s_armed_trigger
    |=> run_q == RUN_ACTIVE) else $error("armed trigger did not start");
  run_gate_a: assert property ($rose(running) |-> $past(cmd1_q[CMD1_SCAN_EN]))
    else $error("run began without scan enable");
  conv_in_run_a: assert property (o_conv_start |-> $past(running))
    else $error("conversion outside a run");
  single_stop_a: assert property (conv_pulse && tc4 && !cmd1_q[CMD1_WIDTH]
    |=> run_q == RUN_IDLE) else $error("single stage did not stop");
  ovfl_halt_a: assert property (ovfl_evt |=> ovfl_q && !running)
    else $error("overflow not flagged or run not halted");
  ovrn_halt_a: assert property (ovrn_evt |=> ovrn_q && !running && !o_conv_start)
    else $error("overrun not flagged or run not halted");
  flag_clear_a: assert property (wr_clr && !ovfl_evt && !ovrn_evt
    |=> !ovfl_q && !ovrn_q) else $error("clear left an error flag");
  fifo_empty_a: assert property (wr_clr && i_wdata == WORD_RST
    |=> fifo_empty) else $error("clear did not empty fifo");
  mux_zero_a: assert property (i_wr && i_addr == REG_MUXCNT && i_wdata == WORD_RST
    |=> mux_q == 4'h0) else $error("mux counter not at first entry");
  status_avail_a: assert property (i_rd && i_addr == REG_STATUS
    |=> o_rdata[ST_AVAIL] == !$past(fifo_empty)) else $error("bad available flag");

endmodule // sacq_top

// ===== bench/sacq_conv_model.sv
// Converter stand-in for the sequencer: answers each conversion pulse that finds it idle after a delay.
// Assumes start pulses and the mux selection arrive on the block's own clock.
`timescale 1ns/1ns
module sacq_conv_model
  import sacq_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_start,   // One-cycle conversion pulse from the block.
  input  wire logic        i_slow,    // Makes a conversion outlast the sample interval.
  input  sacq_entry_s      i_sel,     // Channel and gain in force at the pulse.
  output logic             o_done,
  output logic [15:0]      o_data
);
  logic [7:0]  wait_q;   // Cycles left of the conversion in flight.
  logic [11:0] seen_q;   // Pulses seen so far.
  logic [15:0] res_q;    // Result being formed: channel and pulse index.
  initial begin
    wait_q = 8'h00;
    seen_q = 12'h000;
    res_q  = 16'h0000;
    o_done = 1'b0;
    o_data = 16'h0000;
  end
  // A pulse while busy is counted but not answered, as a converter still settling would do.
  // Outside the done cycle the data lines toggle, so no stale value can pass for a result.
  always @(posedge i_sys_clk) begin
    o_done <= 1'b0;
    o_data <= ~o_data;
    if (i_start) begin
      seen_q <= seen_q + 12'h001;
    end
    if (i_start && wait_q == 8'h00) begin
      wait_q <= i_slow ? 8'h28 : 8'h05;
      res_q  <= {i_sel.chan, seen_q};
    end else if (wait_q == 8'h01) begin
      wait_q <= 8'h00;
      o_done <= 1'b1;
      o_data <= res_q;
    end else if (wait_q != 8'h00) begin
      wait_q <= wait_q - 8'h01;
    end
  end
endmodule // sacq_conv_model

// ===== bench/sacq_top_bench.sv
// Self-checking bench for the scanned acquisition sequencer.
// Assumes the converter stand-in and a 1 MHz timebase of ten system clocks.
`timescale 1ns/1ns
module sacq_top_bench
  import sacq_pkg::*;
;
  logic        i_sys_clk = 1'b0;  // 10 MHz system clock.
  logic        i_srst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        trig_n = 1'b1;     // Start pin, idle high.
  logic        slow = 1'b0;
  logic        ext_tb = 1'b0;     // External timebase pin.
  logic        c1_n = 1'b1;       // Counter-one output pin, idle high.
  logic        ext_run = 1'b0;    // Lets the external timebase toggle.
  int          gap = 30;          // Expected clocks between pulses in a run.
  logic        conv_start;
  logic        conv_done;
  logic [15:0] conv_data;
  sacq_entry_s mux_sel;
  int          miscompares = 0;
  int          compares = 0;
  int          cyc = 0, last = 0, tot = 0, base = 0, bad = 0, bad0 = 0;
  logic [15:0] v;
  always #50 i_sys_clk = ~i_sys_clk;
  // The external timebase and counter-one pins are driven by the bench.
  sacq_top DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_start_trigger_n(trig_n),
    .i_external_timebase_input(ext_tb), .i_counter_one_output(c1_n),
    .o_conv_start(conv_start), .o_mux_sel(mux_sel), .i_conv_done(conv_done),
    .i_conv_data(conv_data));
  sacq_conv_model conv (.i_sys_clk(i_sys_clk), .i_start(conv_start), .i_slow(slow),
    .i_sel(mux_sel), .o_done(conv_done), .o_data(conv_data));
  // Counts pulses and flags any spacing other than gap clocks within a run.
  // While enabled, the external timebase rises once every four clocks.
  always @(posedge i_sys_clk) begin
    cyc++;
    if (ext_run && cyc[0]) begin
      ext_tb <= ~ext_tb;
    end
    if (conv_start === 1'b1) begin
      if (tot != base && cyc - last != gap) bad++;
      last = cyc;
      tot++;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One write cycle; the strobe drops a cycle later so calls can follow each other.
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge i_sys_clk) wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  // Read data stand only in the cycle after the strobe and are taken there.
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    addr <= a; rd <= 1'b1;
    @(posedge i_sys_clk) rd <= 1'b0;
    @(posedge i_sys_clk) d = rdata;
  endtask
  // Programs a three-count interval on the given timebase and a one- or two-stage
  // count, triggers, then waits a bounded time for nexp pulses.
  task automatic arm_run(input logic [15:0] mode, input logic [15:0] n,
                         input logic [15:0] cmd1, input logic pin, input logic two,
                         input int nexp);
    wreg(REG_CTRCMD, CC_SEL_M3);
    wreg(REG_CTRDATA, mode);
    wreg(REG_CTRCMD, CC_SEL_L3);
    wreg(REG_CTRDATA, 16'h0002);
    wreg(REG_CTRCMD, CC_LOAD3);
    wreg(REG_CTRCMD, CC_STEP3);
    wreg(REG_CTRDATA, 16'h0003);
    wreg(REG_CTRCMD, CC_ARM3);
    wreg(REG_CTRCMD, CC_SEL_M4);
    wreg(REG_CTRDATA, 16'h1025);
    wreg(REG_CTRCMD, CC_SEL_L4);
    wreg(REG_CTRDATA, n - 16'h0001);
    wreg(REG_CTRCMD, CC_LOAD4);
    if (two) begin
      wreg(REG_CTRDATA, 16'h0000);
    end else begin
      wreg(REG_CTRCMD, CC_STEP4);
    end
    wreg(REG_CTRCMD, CC_ARM4);
    if (two) begin
      wreg(REG_CTRCMD, CC_SEL_M5);
      wreg(REG_CTRDATA, 16'h0025);
      wreg(REG_CTRCMD, CC_SEL_L5);
      wreg(REG_CTRDATA, 16'h0002);
      wreg(REG_CTRCMD, CC_LDARM5);
    end
    wreg(REG_ADCLR, 16'h0000);
    wreg(REG_MUXCNT, 16'h0000);
    wreg(REG_CMD1, cmd1);
    base = tot;
    bad0 = bad;
    gap = (mode == MODE_EXT) ? 12 : 30;
    if (pin) begin
      trig_n <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      trig_n <= 1'b1;
    end else begin
      wreg(REG_START, 16'h0000);
    end
    for (int k = 0; k < 900 && tot - base < nexp; k++) @(posedge i_sys_clk);
    // A run that never delivers its pulses ends the regression here.
    if (tot - base < nexp) begin
      chk(16'(tot - base), 16'(nexp));
      close_out();
    end
    // Extra time in which an overshooting run would show more pulses.
    repeat (100) @(posedge i_sys_clk);
  endtask
  task automatic t_reset();
    rreg(REG_STATUS, v); chk(v, 16'h0000);
    rreg(4'h7, v); chk(v, 16'h0000);
    rreg(REG_FIFO, v); chk(v, 16'h0000);
  endtask
  // Two-entry scan started by the pin; a count of four ends on the pulse that
  // finds the stage at zero, so three results: pacing, mux and FIFO order.
  task automatic t_scan();
    wreg(REG_MUXCNT, 16'h0000);
    wreg(REG_MUXGAIN, 16'h0005);
    wreg(REG_MUXCNT, 16'h0001);
    wreg(REG_MUXGAIN, 16'h0109);
    arm_run(MODE_1MHZ, 16'h0004, 16'h0003, 1'b1, 1'b0, 3);
    chk(16'(tot - base), 16'h0003);
    chk(16'(bad - bad0), 16'h0000);
    rreg(REG_STATUS, v); chk(v, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      rreg(REG_FIFO, v);
      chk(v, {(i % 2) ? 4'h9 : 4'h5, 12'(base + i)});
    end
    rreg(REG_STATUS, v); chk(v, 16'h0000);
  endtask
  task automatic t_gate();
    arm_run(MODE_1MHZ, 16'h0004, 16'h0001, 1'b0, 1'b0, 0);
    chk(16'(tot - base), 16'h0000);
  endtask
  // External edges every four clocks pace the three-count interval.
  task automatic t_ext();
    ext_run <= 1'b1;
    arm_run(MODE_EXT, 16'h0004, 16'h0003, 1'b0, 1'b0, 3);
    ext_run <= 1'b0;
    chk(16'(tot - base), 16'h0003);
    chk(16'(bad - bad0), 16'h0000);
  endtask
  // With scan divide the mux follows counter-one low pulses and wraps after the last entry.
  task automatic t_div();
    wreg(REG_CMD1, 16'h000A);
    wreg(REG_MUXCNT, 16'h0000);
    for (int i = 1; i >= 0; i--) begin
      c1_n <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      c1_n <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      rreg(REG_MUXCNT, v);
      chk(v, 16'(i));
    end
  endtask
  // A two-stage count of 2_0003 outlives the pulses that end a one-stage run;
  // clearing the enable then stops it.
  task automatic t_two();
    arm_run(MODE_1MHZ, 16'h0003, 16'h0007, 1'b0, 1'b1, 4);
    rreg(REG_STATUS, v);
    chk(v, 16'h0009);
    wreg(REG_CMD1, 16'h0000);
    rreg(REG_STATUS, v);
    chk(v, 16'h0001);
  endtask
  // Nothing is read, so the seventeenth result finds the FIFO full.
  task automatic t_ovfl();
    arm_run(MODE_1MHZ, 16'h0014, 16'h0003, 1'b0, 1'b0, 17);
    chk(16'(tot - base), 16'h0011);
    rreg(REG_STATUS, v); chk(v, 16'h0003);
    wreg(REG_ADCLR, 16'h0000);
    rreg(REG_STATUS, v); chk(v, 16'h0000);
  endtask
  // Conversions outlast the interval; a non-zero clear drops the flag but keeps the data.
  task automatic t_ovrn();
    slow <= 1'b1;
    arm_run(MODE_1MHZ, 16'h0004, 16'h0003, 1'b0, 1'b0, 1);
    chk(16'(tot - base), 16'h0001);
    rreg(REG_STATUS, v); chk(v, 16'h0005);
    wreg(REG_ADCLR, 16'h0001);
    rreg(REG_STATUS, v); chk(v, 16'h0001);
    slow <= 1'b0;
  endtask
  task automatic close_out();
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    @(posedge i_sys_clk);
    t_reset();
    t_scan();
    t_gate();
    t_ext();
    t_div();
    t_two();
    t_ovfl();
    t_ovrn();
    close_out();
  end
endmodule // sacq_top_bench
